// ===== core/tweep_pkg.sv
// Package for the two-wire serial EEPROM target: density options, field positions,
// timing constants and the carrier structs shared by the core and its helpers.
// Assumes a 100 MHz system clock that oversamples the two-wire pins.
package tweep_pkg;

	// Density selector values: 1K, 2K, 4K, 8K, 16K
	localparam logic [2:0] DENS_1K = 3'h0;
	localparam logic [2:0] DENS_2K = 3'h1;
	localparam logic [2:0] DENS_4K = 3'h2;
	localparam logic [2:0] DENS_8K = 3'h3;
	localparam logic [2:0] DENS_16K = 3'h4;

	// Widest word address and array depth
	localparam int ADDR_W = 11;
	localparam int MEM_DEPTH = 2048;

	// Fixed device-type pattern in the top four bits of the address word
	localparam logic [3:0] DEV_TYPE = 4'ha;

	// Bit positions inside the device address word
	localparam int DEV_RW_BIT = 0;
	localparam int DEV_SEL_LSB = 1;
	localparam int DEV_TYPE_LSB = 4;

	// Reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 11'h000;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [2:0] BIT_RST = 3'h7;

	// Clock rate and programming cycle time
	localparam int CLK_MHZ = 100;
	localparam int PROG_TIME_US = 5000;
	localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
	localparam int PROG_CNT_W = 20;

	// Filtered view of the two-wire pins after synchronising
	typedef struct packed {
		logic scl;
		logic sda;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} tweep_bus_t;

	// One byte handed to the programming engine
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] data;
	} tweep_wr_t;

endpackage

// ===== core/tweep_sync.sv
// Two-flop synchroniser and edge/condition detector for the two-wire pins.
// Assumes SCL and SDA are asynchronous to CLK and much slower than it.
`timescale 1ns/1ns
module tweep_sync
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Raw pins
	input wire logic scl_in,
	input wire logic sda_in,
	// Conditioned view
	output tweep_pkg::tweep_bus_t bus
);

	logic [1:0] scl_s_r; // Synchroniser chain for the clock pin
	logic [1:0] sda_s_r; // Synchroniser chain for the data pin
	logic scl_d_r; // Previous stable clock level
	logic sda_d_r; // Previous stable data level

	// Two flops per pin; the first stage feeds only the second
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			scl_s_r <= 2'h3;
			sda_s_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_s_r <= {scl_s_r[0], scl_in};
			sda_s_r <= {sda_s_r[0], sda_in};
			scl_d_r <= scl_s_r[1];
			sda_d_r <= sda_s_r[1];
		end
	end

	// Edges and bus conditions from the stable stage only
	always_comb
	begin
		bus.scl = scl_s_r[1];
		bus.sda = sda_s_r[1];
		bus.scl_rise = scl_s_r[1] & ~scl_d_r;
		bus.scl_fall = ~scl_s_r[1] & scl_d_r;
		bus.start = scl_s_r[1] & scl_d_r & sda_d_r & ~sda_s_r[1];
		bus.stop = scl_s_r[1] & scl_d_r & ~sda_d_r & sda_s_r[1];
	end

endmodule

// ===== core/tweep_prog.sv
// Self-timed programming engine: collects page bytes, then commits them after stop.
// Assumes the caller presents bytes only while not busy.
`timescale 1ns/1ns
module tweep_prog
#(
	parameter int PROG_CYCLES = tweep_pkg::PROG_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Byte capture and commit
	input wire logic stage_we,
	input tweep_pkg::tweep_wr_t stage,
	input wire logic commit,
	input wire logic discard,
	// Array write port
	output logic mem_we,
	output tweep_pkg::tweep_wr_t mem_wr,
	// Status
	output logic busy
);

	tweep_pkg::tweep_wr_t buf_r [16]; // Page staging buffer
	logic [15:0] vld_r; // One flag per slot that holds a staged byte
	logic [4:0] idx_r; // Commit walk index
	logic [tweep_pkg::PROG_CNT_W-1:0] tmr_r; // Cycle timer
	logic busy_r;

	// Slot flags; a page that starts mid-way marks only the slots it really used
	always_ff @(posedge clk)
	begin
		if (srst)
			vld_r <= 16'h0000;
		else if (discard || (busy_r && tmr_r == '0))
			vld_r <= 16'h0000;
		else if (stage_we && !busy_r)
			vld_r[stage.addr[3:0]] <= 1'b1;
	end

	// Stage bytes; a wrapped page reuses its slot so later data wins
	always_ff @(posedge clk)
	begin
		if (stage_we && !busy_r)
			buf_r[stage.addr[3:0]] <= stage;
	end

	// Timer runs the full programming time; array walk happens at its start
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			busy_r <= 1'b0;
			tmr_r <= '0;
			idx_r <= 5'h00;
		end
		else if (!busy_r && commit && vld_r != 16'h0000)
		begin
			busy_r <= 1'b1;
			tmr_r <= tweep_pkg::PROG_CNT_W'(PROG_CYCLES - 1);
			idx_r <= 5'h00;
		end
		else if (busy_r)
		begin
			if (tmr_r != '0)
				tmr_r <= tmr_r - 1'b1;
			else
				busy_r <= 1'b0;
			if (idx_r != 5'h10)
				idx_r <= idx_r + 5'h01;
		end
	end

	// Slots are indexed by low address; only flagged slots are written out
	logic slot_ok;
	assign slot_ok = vld_r[idx_r[3:0]];

	// Array write strobe during the walk
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			mem_we <= 1'b0;
			mem_wr <= '0;
		end
		else
		begin
			mem_we <= busy_r && idx_r != 5'h10 && slot_ok;
			mem_wr <= buf_r[idx_r[3:0]];
		end
	end

	assign busy = busy_r;

endmodule

// ===== core/tweep_top.sv
// Two-wire serial EEPROM target, 1K to 16K, with page write and sequential read.
// Assumes SCL and SDA arrive asynchronously and much slower than the 100 MHz CLK.
`timescale 1ns/1ns
module tweep_top
#(
	parameter logic [2:0] DENSITY = tweep_pkg::DENS_16K,
	parameter int PROG_CYCLES = tweep_pkg::PROG_CYCLES
)
(
	// Clock and reset
	input wire logic CLK,
	input wire logic SRST,
	// Two-wire link
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	// Strap pins
	input wire logic SELECT_PIN_HIGH,
	input wire logic SELECT_PIN_MID,
	input wire logic SELECT_PIN_LOW,
	input wire logic WRITE_PROTECT,
	// Status
	output logic BUSY
);

	// Controller phases
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DEV = 3'b001,
		ST_WADDR = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_RACK = 3'b101
	} tweep_state_t;

	// Mask of select pins compared at this density
	function automatic logic [2:0] sel_mask(input logic [2:0] d);
		case (d)
			tweep_pkg::DENS_4K: sel_mask = 3'h6;
			tweep_pkg::DENS_8K: sel_mask = 3'h4;
			tweep_pkg::DENS_16K: sel_mask = 3'h0;
			default: sel_mask = 3'h7;
		endcase
	endfunction

	// Mask of valid word address bits at this density
	function automatic logic [10:0] addr_mask(input logic [2:0] d);
		case (d)
			tweep_pkg::DENS_1K: addr_mask = 11'h07f;
			tweep_pkg::DENS_2K: addr_mask = 11'h0ff;
			tweep_pkg::DENS_4K: addr_mask = 11'h1ff;
			tweep_pkg::DENS_8K: addr_mask = 11'h3ff;
			default: addr_mask = 11'h7ff;
		endcase
	endfunction

	localparam logic [2:0] SEL_M = sel_mask(DENSITY);
	localparam logic [10:0] ADR_M = addr_mask(DENSITY);
	localparam logic [10:0] PAGE_M = (DENSITY <= tweep_pkg::DENS_2K) ? 11'h007 : 11'h00f;

	tweep_pkg::tweep_bus_t bus; // Conditioned pins
	tweep_pkg::tweep_wr_t stage; // Byte to stage
	tweep_pkg::tweep_wr_t mem_wr; // Array write
	logic mem_we;
	logic prog_busy;
	logic [7:0] mem_r [tweep_pkg::MEM_DEPTH]; // Array storage
	tweep_state_t state_r;
	logic [7:0] shift_r; // Receive or transmit shift register
	logic [2:0] bit_r; // Bit position within byte
	logic ack_slot_r; // In the ninth clock of a byte
	logic full_r; // Eight bits taken, the ack slot opens at the next fall
	logic [10:0] addr_r; // Internal address counter
	logic [2:0] page_sel_r; // Page bits taken from the address word
	logic [1:0] wp_s_r; // Write protect synchroniser
	logic [2:0] sel_s0_r; // Select pin first stage
	logic [2:0] sel_s1_r; // Select pin second stage
	logic wrote_r; // Data staged in this transaction
	logic stage_we_r;
	logic commit_r;
	logic discard_r;
	logic sda_low_r; // Drive low when set
	logic [7:0] rd_byte; // Array byte at counter

	tweep_sync u_sync
	(
		.clk(CLK),
		.srst(SRST),
		.scl_in(SCL_I),
		.sda_in(SDA_I),
		.bus(bus)
	);

	tweep_prog #(.PROG_CYCLES(PROG_CYCLES)) u_prog
	(
		.clk(CLK),
		.srst(SRST),
		.stage_we(stage_we_r),
		.stage(stage),
		.commit(commit_r),
		.discard(discard_r),
		.mem_we(mem_we),
		.mem_wr(mem_wr),
		.busy(prog_busy)
	);

	// Straps pass two flops before use
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			wp_s_r <= 2'h3;
			sel_s0_r <= 3'h0;
			sel_s1_r <= 3'h0;
		end
		else
		begin
			wp_s_r <= {wp_s_r[0], WRITE_PROTECT};
			sel_s0_r <= {SELECT_PIN_HIGH, SELECT_PIN_MID, SELECT_PIN_LOW};
			sel_s1_r <= sel_s0_r;
		end
	end

	// Array write port; contents are not cleared by reset
	always_ff @(posedge CLK)
	begin
		if (mem_we)
			mem_r[mem_wr.addr & ADR_M] <= mem_wr.data;
	end

	assign rd_byte = mem_r[addr_r & ADR_M];

	// Bit engine and protocol sequencer; it also owns the pin pull-down, so that
	// every assertion of the pull-down follows a decoded clock fall
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			state_r <= ST_IDLE;
			shift_r <= tweep_pkg::BYTE_RST;
			bit_r <= tweep_pkg::BIT_RST;
			full_r <= 1'b0;
			ack_slot_r <= 1'b0;
			addr_r <= tweep_pkg::ADDR_RST;
			page_sel_r <= 3'h0;
			wrote_r <= 1'b0;
			stage_we_r <= 1'b0;
			commit_r <= 1'b0;
			discard_r <= 1'b0;
			sda_low_r <= 1'b0;
			stage <= '0;
		end
		else
		begin
			stage_we_r <= 1'b0;
			commit_r <= 1'b0;
			discard_r <= 1'b0;
			if (prog_busy)
			begin
				// Inputs ignored and the pin released while programming
				state_r <= ST_IDLE;
				full_r <= 1'b0;
				ack_slot_r <= 1'b0;
				sda_low_r <= 1'b0;
			end
			else if (bus.start)
			begin
				// Restart drops staged bytes uncommitted; a partial byte is never staged
				state_r <= ST_DEV;
				bit_r <= tweep_pkg::BIT_RST;
				full_r <= 1'b0;
				ack_slot_r <= 1'b0;
				sda_low_r <= 1'b0;
				if (wrote_r)
					discard_r <= 1'b1;
				wrote_r <= 1'b0;
			end
			else if (bus.stop)
			begin
				// Only whole staged bytes commit, and never under protection
				if (wrote_r && !wp_s_r[1])
					commit_r <= 1'b1;
				else if (wrote_r)
					discard_r <= 1'b1;
				wrote_r <= 1'b0;
				state_r <= ST_IDLE;
				full_r <= 1'b0;
				ack_slot_r <= 1'b0;
				sda_low_r <= 1'b0;
			end
			else if (bus.scl_rise && state_r != ST_IDLE)
			begin
				if (ack_slot_r)
				begin
					// Controller's answer to a read byte: a high level ends the read
					if (state_r == ST_RACK && bus.sda)
						state_r <= ST_IDLE;
				end
				else
				begin
					// Sample on the rising edge; a read recirculates its own bit
					shift_r <= {shift_r[6:0], (state_r == ST_RDATA) ? shift_r[7] : bus.sda};
					if (bit_r == 3'h0)
						full_r <= 1'b1;
					else
						bit_r <= bit_r - 3'h1;
				end
			end
			else if (bus.scl_fall && state_r != ST_IDLE)
			begin
				if (full_r)
				begin
					// Eighth bit taken: decide and open the ack slot
					full_r <= 1'b0;
					ack_slot_r <= 1'b1;
					sda_low_r <= 1'b0;
					case (state_r)
						ST_DEV:
						begin
							if (shift_r[7:4] == tweep_pkg::DEV_TYPE
								&& ((shift_r[3:1] ^ sel_s1_r) & SEL_M) == 3'h0)
							begin
								sda_low_r <= 1'b1;
								page_sel_r <= shift_r[3:1] & ~SEL_M;
								if (shift_r[tweep_pkg::DEV_RW_BIT])
								begin
									state_r <= ST_RDATA;
									shift_r <= rd_byte;
								end
								else
									state_r <= ST_WADDR;
							end
							else
								state_r <= ST_IDLE;
						end
						ST_WADDR:
						begin
							sda_low_r <= 1'b1;
							addr_r <= {page_sel_r, shift_r} & ADR_M;
							state_r <= ST_WDATA;
						end
						ST_WDATA:
						begin
							sda_low_r <= 1'b1;
							stage.addr <= addr_r;
							stage.data <= shift_r;
							stage_we_r <= 1'b1;
							wrote_r <= 1'b1;
							addr_r <= (addr_r & ~PAGE_M) | ((addr_r + 11'h001) & PAGE_M);
						end
						ST_RDATA:
						begin
							// Byte sent: release for the controller, counter moves on even on a nack
							addr_r <= (addr_r + 11'h001) & ADR_M;
							state_r <= ST_RACK;
						end
						default: state_r <= ST_IDLE;
					endcase
				end
				else if (ack_slot_r)
				begin
					// Ack slot over: a read puts out the first bit of its byte
					ack_slot_r <= 1'b0;
					bit_r <= tweep_pkg::BIT_RST;
					if (state_r == ST_RACK)
					begin
						state_r <= ST_RDATA;
						shift_r <= rd_byte;
						sda_low_r <= ~rd_byte[7];
					end
					else if (state_r == ST_RDATA)
						sda_low_r <= ~shift_r[7];
					else
						sda_low_r <= 1'b0;
				end
				else if (state_r == ST_RDATA)
					sda_low_r <= ~shift_r[7];
			end
		end
	end

	// Open drain: output value fixed low, enable carries the data
	always_ff @(posedge CLK)
	begin
		if (SRST)
		begin
			SDA_O <= 1'b0;
			SDA_OE <= 1'b0;
			BUSY <= 1'b0;
		end
		else
		begin
			SDA_O <= 1'b0;
			SDA_OE <= sda_low_r;
			BUSY <= prog_busy;
		end
	end

	// Checks
	chk_no_drive_busy: assert property (@(posedge CLK) disable iff (SRST)
		prog_busy |-> ##2 !SDA_OE)
		else $error("pin driven while programming");
	chk_oe_on_fall: assert property (@(posedge CLK) disable iff (SRST)
		$rose(sda_low_r) |-> $past(bus.scl_fall))
		else $error("data changed off falling edge");
	chk_out_low: assert property (@(posedge CLK) disable iff (SRST)
		SDA_O == 1'b0)
		else $error("pin driven high");
	chk_wp_commit: assert property (@(posedge CLK) disable iff (SRST)
		commit_r |-> !$past(wp_s_r[1]))
		else $error("commit under write protect");
	chk_busy_timer: assert property (@(posedge CLK) disable iff (SRST)
		$rose(prog_busy) |-> prog_busy [*8])
		else $error("programming ended early");
	chk_page_wrap: assert property (@(posedge CLK) disable iff (SRST)
		stage_we_r |-> (addr_r & ~PAGE_M) == (stage.addr & ~PAGE_M))
		else $error("write address left its page");
	chk_idle_busy: assert property (@(posedge CLK) disable iff (SRST)
		prog_busy |=> state_r == ST_IDLE)
		else $error("sequencer active while programming");
	chk_stage_full: assert property (@(posedge CLK) disable iff (SRST)
		stage_we_r |-> $past(state_r) == ST_WDATA)
		else $error("byte staged outside data phase");
	cov_write: cover property (@(posedge CLK) commit_r);
	cov_read: cover property (@(posedge CLK) state_r == ST_RDATA);
	cov_poll: cover property (@(posedge CLK) prog_busy && bus.start);

endmodule

// ===== testbench/tweep_ctl.sv
// Two-wire bus controller model: drives SCL and pulls SDA low.
// Assumes a pull-up on the wire, paced by the bench clock's falling edge.
`timescale 1ns/1ns
module tweep_ctl
(
	// Pacing clock
	input wire logic clk,
	// Wire level seen back
	input wire logic sda,
	// Link outputs
	output logic scl,
	output logic sda_low
);
	// Bus idles released, clock high
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// Quarter bit of 2 clocks gives the 80 ns link clock
	task automatic q();
		repeat (2) @(negedge clk);
	endtask
	// Start or repeated start: data falls with clock high
	task automatic start();
		@(negedge clk);
		sda_low = 1'b0;
		q();
		scl = 1'b1;
		q();
		sda_low = 1'b1;
		q();
		scl = 1'b0;
		q();
	endtask
	// Stop: data rises with clock high
	task automatic stop();
		@(negedge clk);
		sda_low = 1'b1;
		q();
		scl = 1'b1;
		q();
		sda_low = 1'b0;
		q();
	endtask
	// One bit: data moves mid-low, sampled mid-high
	task automatic bit_io(input logic b, output logic r);
		q();
		sda_low = ~b;
		q();
		scl = 1'b1;
		q();
		r = sda;
		q();
		scl = 1'b0;
	endtask
	// Byte out MSB first, then the ack slot is released
	task automatic put(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	// Byte in; our ack continues a read, a nack ends it
	task automatic get(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
	endtask
endmodule

// ===== testbench/tweep_top_test.sv
// Self-checking bench for the two-wire EEPROM target at 4K density.
// Assumes the controller model above and a short programming cycle.
`timescale 1ns/1ns
module tweep_top_test;
	// Bench-driven inputs
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic pin_hi = 1'b1;
	logic pin_mid = 1'b0;
	logic pin_lo = 1'b1;
	logic wp = 1'b0;
	// Design and model outputs
	logic scl, sda_low, sda_o, sda_oe, busy;
	// Wire with pull-up: low when either side pulls
	wire logic sda_w = ~(sda_low | (sda_oe & ~sda_o));
	// Shadow of the array, built from the page rules
	logic [7:0] exp_mem [512];
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	tweep_top #(.DENSITY(tweep_pkg::DENS_4K), .PROG_CYCLES(200)) tweep_top_inst
	(
		.CLK(clk), .SRST(srst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE(sda_oe),
		.SELECT_PIN_HIGH(pin_hi), .SELECT_PIN_MID(pin_mid), .SELECT_PIN_LOW(pin_lo),
		.WRITE_PROTECT(wp), .BUSY(busy)
	);
	tweep_ctl ctl (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(sda_low));
	always #5 clk = ~clk;
	// Hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 60000)
		begin
			err_count = err_count + 1;
			close_out();
		end
	end
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Address word for straps high=1 mid=0; page bit is word address bit 8
	function automatic logic [7:0] dev(input logic [8:0] a, input logic rw);
		return {tweep_pkg::DEV_TYPE, 2'b10, a[8], rw};
	endfunction
	// Write n bytes base+i from a; each must be acked
	task automatic wr_mem(input logic [8:0] a, input logic [7:0] base, input int n);
		logic ack;
		ctl.start();
		ctl.put(dev(a, 1'b0), ack);
		chk({7'h0, ack}, 8'h01);
		ctl.put(a[7:0], ack);
		chk({7'h0, ack}, 8'h01);
		for (int i = 0; i < n; i++)
		begin
			ctl.put(base + 8'(i), ack);
			chk({7'h0, ack}, 8'h01);
			// Low four bits only advance, so the page wraps
			if (!wp)
				exp_mem[{a[8:4], a[3:0] + 4'(i)}] = base + 8'(i);
		end
		ctl.stop();
	endtask
	// First poll falls inside the cycle and must be refused
	task automatic poll(input logic [8:0] a);
		logic ack;
		int n;
		n = 0;
		ack = 1'b0;
		repeat (8) @(negedge clk);
		chk({7'h0, busy}, 8'h01);
		while (!ack && n < 20)
		begin
			ctl.start();
			ctl.put(dev(a, 1'b0), ack);
			ctl.stop();
			n++;
		end
		chk({7'h0, ack}, 8'h01);
		chk({7'h0, n > 1}, 8'h01);
	endtask
	// Random then sequential read of n bytes from a
	task automatic rd_seq(input logic [8:0] a, input int n);
		logic ack;
		logic [7:0] d;
		ctl.start();
		ctl.put(dev(a, 1'b0), ack);
		ctl.put(a[7:0], ack);
		ctl.start();
		ctl.put(dev(a, 1'b1), ack);
		chk({7'h0, ack}, 8'h01);
		for (int i = 0; i < n; i++)
		begin
			ctl.get(i < n - 1, d);
			chk(d, exp_mem[9'(a + 9'(i))]);
		end
		ctl.stop();
	endtask
	// Wrong mid strap bit gets no ack; low strap is a page bit here
	task automatic t_select();
		logic ack;
		ctl.start();
		ctl.put({tweep_pkg::DEV_TYPE, 4'b1100}, ack);
		chk({7'h0, ack}, 8'h00);
		ctl.stop();
		pin_lo = 1'b0;
		$display("test select done");
	endtask
	// Overlong page write, polling, read back, then current read
	task automatic t_page();
		logic ack;
		logic [7:0] d;
		wr_mem(9'h10e, 8'h20, 18);
		poll(9'h10e);
		rd_seq(9'h100, 15);
		ctl.start();
		ctl.put(dev(9'h10f, 1'b1), ack);
		ctl.get(1'b0, d);
		chk(d, exp_mem[9'h10f]);
		ctl.stop();
		$display("test page done");
	endtask
	// Read runs off the last byte onto the first
	task automatic t_wrap();
		wr_mem(9'h1ff, 8'h5a, 1);
		poll(9'h1ff);
		wr_mem(9'h000, 8'ha5, 1);
		poll(9'h000);
		rd_seq(9'h1ff, 2);
		$display("test wrap done");
	endtask
	// Protected write is acked but never programs
	task automatic t_prot();
		wp = 1'b1;
		wr_mem(9'h100, 8'hee, 1);
		repeat (20) @(negedge clk);
		chk({7'h0, busy}, 8'h00);
		wp = 1'b0;
		rd_seq(9'h100, 1);
		$display("test protect done");
	endtask
	// Stop after half a data byte programs nothing
	task automatic t_abort();
		logic ack;
		logic r;
		ctl.start();
		ctl.put(dev(9'h101, 1'b0), ack);
		ctl.put(8'h01, ack);
		for (int i = 0; i < 4; i++)
			ctl.bit_io(1'b0, r);
		ctl.stop();
		repeat (20) @(negedge clk);
		chk({7'h0, busy}, 8'h00);
		rd_seq(9'h101, 1);
		$display("test abort done");
	endtask
	// Reset for three cycles, then the scenarios in turn
	initial
	begin
		repeat (3) @(negedge clk);
		srst = 1'b0;
		repeat (8) @(negedge clk);
		t_select();
		t_page();
		t_wrap();
		t_prot();
		t_abort();
		close_out();
	end
endmodule
